// File: hdl/uisc_pkg.sv
// Constants and types for the USB interrupt and suspend controller
//
// Contract
// - Raise suspend flag after the bus stays idle at least 3 ms.
// - Suspend output low normally, high after about 2 ms preparation.
// - Bus-power-detect output falls 2.5 to 3.5 ms after bus power appears.
// - Bus-power-detect output depends only on power-on reset, not hardware reset.
// - Oscillator and clock multiplier stop while suspended.
// - Oscillator-run bit switches the oscillator on and off.
// - Working 48 MHz clock is the 6 MHz source multiplied by eight.
// - After power-on reset wait 3 to 4 ms for the clock to settle.
// - Hardware reset disables all endpoints except the fixed control endpoint.
// - Each event sets its own status bit; enable bit gates the interrupt.
// - Global enable cleared masks every interrupt.
// - Style bit selects level or pulse interrupt; level after reset.
// - Pulse style gives one 166 ns pulse per rise of the ORed bits; code gives 8 cycles of 20 ns, 160 ns.
// - Reading status clears suspend, reset, resume, short-packet, end, frame flags.
// - Endpoint flags clear only when that endpoint's status is read.
// - Bus-state bit tracks the live bus state, never latched.
// - SETUP and OUT events are raised only after the packet is acknowledged.
// - Bulk endpoints raise an event for every ACK on OUT or IN.
// - Isochronous endpoints raise an event on every transaction.
// - Missing frame start gives gated pseudo-frame events every 1 ms.
// - Three missed frame starts in a row enter suspend.
package uisc_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned IDLE_NS       = 3_000_000;
  localparam int unsigned PREP_NS       = 2_000_000;
  localparam int unsigned VBUS_NS       = 3_000_000;
  localparam int unsigned SETTLE_NS     = 4_000_000;
  localparam int unsigned FRAME_NS      = 1_000_000;
  localparam int unsigned PULSE_NS      = 166;
  // Least times and the power-detect delay round up, longest and other typical times round down
  localparam int unsigned IDLE_CYC   =
    (IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PREP_CYC   = PREP_NS / CLK_PERIOD_NS;
  localparam int unsigned VBUS_CYC   =
    (VBUS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_CYC = SETTLE_NS / CLK_PERIOD_NS;
  localparam int unsigned FRAME_CYC  = FRAME_NS / CLK_PERIOD_NS;
  localparam logic [3:0]  PULSE_CYC  = 4'(PULSE_NS / CLK_PERIOD_NS);
  localparam logic [3:0]  PLL_MULT   = 4'h8;

  localparam int unsigned CNT_W = 18;
  typedef logic [CNT_W-1:0] uisc_cnt_t;

  // ==========================================================
  // Status layout
  localparam int unsigned N_EP     = 16;
  localparam int unsigned ST_W     = 24;
  localparam int unsigned B_RESET  = 0;
  localparam int unsigned B_SUSP   = 1;
  localparam int unsigned B_RESUME = 2;
  localparam int unsigned B_SOF    = 3;
  localparam int unsigned B_PFRAME = 4;
  localparam int unsigned B_SPEOT  = 5;
  localparam int unsigned B_EOT    = 6;
  localparam int unsigned B_BUS    = 7;
  localparam int unsigned B_EP0    = 8;
  localparam logic [ST_W-1:0] CLR_ON_READ = 24'h00_007F;

  // ==========================================================
  // Reset values
  localparam logic [N_EP-1:0] EP_EN_RST  = 16'h0001;
  localparam logic            OSC_RUN_RST = 1'b1;
  localparam logic            STYLE_PULSE = 1'b1;
  localparam logic            STYLE_RST   = 1'b0;
  localparam logic [1:0]      SOF_MISS_MAX = 2'h3;

  typedef enum logic [1:0] {
    S_RUN,
    S_PREP,
    S_SUSP
  } uisc_susp_e;

endpackage : uisc_pkg

// File: hdl/uisc_ctrl.sv
// Interrupt, suspend and power-detect control of the USB peripheral
module uisc_ctrl
  import uisc_pkg::*;
#(
  parameter int unsigned P_IDLE_CYC   = IDLE_CYC,
  parameter int unsigned P_PREP_CYC   = PREP_CYC,
  parameter int unsigned P_VBUS_CYC   = VBUS_CYC,
  parameter int unsigned P_SETTLE_CYC = SETTLE_CYC,
  parameter int unsigned P_FRAME_CYC  = FRAME_CYC
) (
  input  wire logic            sys_clk,
  input  wire logic            rstn,
  input  wire logic            por_n,
  input  wire logic            bus_idle_pin,
  input  wire logic            vbus_pin,
  input  wire logic            enter_suspend_cmd,
  input  wire logic            ev_bus_reset,
  input  wire logic            ev_resume,
  input  wire logic            ev_sof,
  input  wire logic            ev_short_packet_end_flag,
  input  wire logic            ev_eot,
  input  wire logic [N_EP-1:0] ep_pkt_acked,
  input  wire logic [N_EP-1:0] ep_iso_txn,
  input  wire logic [N_EP-1:0] ep_is_iso,
  input  wire logic            irq_status_rd,
  input  wire logic [N_EP-1:0] ep_status_rd,
  input  wire logic [ST_W-1:0] irq_enable,
  input  wire logic            global_irq_enable,
  input  wire logic            hwcfg_wr,
  input  wire logic            hwcfg_osc_run,
  input  wire logic            hwcfg_style,
  input  wire logic            ep_cfg_wr,
  input  wire logic [N_EP-1:0] ep_cfg_wdata,
  output logic                 irq_n,
  output logic [ST_W-1:0]      irq_status,
  output logic                 suspend_out,
  output logic                 osc_enable,
  output logic                 pll_enable,
  output logic [3:0]           pll_mult,
  output logic                 bus_power_detect_n,
  output logic                 clk_ready,
  output logic                 osc_run_bit,
  output logic                 irq_signal_style,
  output logic [N_EP-1:0]      ep_enable
);

  // ==========================================================
  // Helpers
  function automatic uisc_cnt_t cnt_step(uisc_cnt_t c, logic run,
                                         int unsigned lim);
    if (!run)
      return '0;
    if (c == uisc_cnt_t'(lim - 1))
      return c;
    return c + uisc_cnt_t'(1);
  endfunction : cnt_step

  function automatic logic cnt_done(uisc_cnt_t c, int unsigned lim);
    return c == uisc_cnt_t'(lim - 1);
  endfunction : cnt_done

  // ==========================================================
  // State under hardware reset
  typedef struct packed {
    logic            bs1, bs2, bs3, bus_idle;
    logic [ST_W-1:0] status;
    logic            any_d;
    logic [3:0]      pulse_cnt;
    logic            irq_n;
    uisc_cnt_t       idle_cnt;
    logic            idle_fired;
    uisc_cnt_t       frame_cnt;
    logic [1:0]      sof_miss;
    uisc_susp_e      susp;
    uisc_cnt_t       prep_cnt;
    logic            susp_ind;
    logic            osc_run;
    logic            style;
    logic            osc_en;
    logic [N_EP-1:0] ep_en;
  } uisc_st_s;

  // State under power-on reset only
  typedef struct packed {
    logic      vs1, vs2, vs3, vbus;
    uisc_cnt_t vbus_cnt;
    logic      vbdet_n;
    uisc_cnt_t settle_cnt;
    logic      ready;
  } uisc_por_s;

  uisc_st_s  st_reg, st_next;
  uisc_por_s po_reg, po_next;

  logic            any_irq;
  logic [ST_W-1:0] set_v;
  logic [ST_W-1:0] clr_v;
  logic [N_EP-1:0] ep_ev;
  logic            frame_miss;
  logic            idle_hit;

  // ==========================================================
  // Event logging and interrupt output
  always_comb begin
    st_next = st_reg;
    // Pin sync; second and third stage must agree
    st_next.bs1 = bus_idle_pin;
    st_next.bs2 = st_reg.bs1;
    st_next.bs3 = st_reg.bs2;
    if (st_reg.bs2 == st_reg.bs3)
      st_next.bus_idle = st_reg.bs3;

    // Idle timer, one suspend flag per idle period
    st_next.idle_cnt = cnt_step(st_reg.idle_cnt,
      st_reg.bus_idle && st_reg.susp == S_RUN, P_IDLE_CYC);
    idle_hit = cnt_done(st_reg.idle_cnt, P_IDLE_CYC) && !st_reg.idle_fired
               && st_reg.bus_idle && st_reg.susp == S_RUN;
    if (!st_reg.bus_idle)
      st_next.idle_fired = 1'b0;
    else if (idle_hit)
      st_next.idle_fired = 1'b1;

    // Frame watchdog restarts on every real frame start
    frame_miss = cnt_done(st_reg.frame_cnt, P_FRAME_CYC) && !ev_sof;
    if (ev_sof || st_reg.susp != S_RUN || frame_miss)
      st_next.frame_cnt = '0;
    else
      st_next.frame_cnt = st_reg.frame_cnt + uisc_cnt_t'(1);
    if (ev_sof || st_reg.susp != S_RUN)
      st_next.sof_miss = '0;
    else if (frame_miss && st_reg.sof_miss != SOF_MISS_MAX)
      st_next.sof_miss = st_reg.sof_miss + 2'h1;

    // Endpoint events: iso per transaction, others only on ACK
    for (int i = 0; i < N_EP; i++)
      ep_ev[i] = ep_is_iso[i] ? ep_iso_txn[i] : ep_pkt_acked[i];

    set_v = '0;
    set_v[B_RESET]  = ev_bus_reset;
    set_v[B_SUSP]   = idle_hit;
    set_v[B_RESUME] = ev_resume;
    set_v[B_SOF]    = ev_sof;
    set_v[B_PFRAME] = frame_miss;
    set_v[B_SPEOT]  = ev_short_packet_end_flag;
    set_v[B_EOT]    = ev_eot;
    set_v[B_EP0 +: N_EP] = ep_ev;
    // Events before the clock settles are not trusted
    if (!po_reg.ready)
      set_v = '0;

    clr_v = '0;
    if (irq_status_rd)
      clr_v = CLR_ON_READ;
    clr_v[B_EP0 +: N_EP] = ep_status_rd;
    // Set beats a clear in the same cycle
    st_next.status = (st_reg.status & ~clr_v) | set_v;
    st_next.status[B_BUS] = st_reg.bus_idle;

    any_irq = global_irq_enable && |(st_reg.status & irq_enable);
    st_next.any_d = any_irq;
    if (st_reg.style == STYLE_PULSE) begin
      // A rise inside a running pulse must not stretch it
      if (any_irq && !st_reg.any_d && st_reg.pulse_cnt == 4'h0)
        st_next.pulse_cnt = PULSE_CYC;
      else if (st_reg.pulse_cnt != 4'h0)
        st_next.pulse_cnt = st_reg.pulse_cnt - 4'h1;
      st_next.irq_n = (st_next.pulse_cnt == 4'h0);
    end else begin
      st_next.pulse_cnt = 4'h0;
      st_next.irq_n = !any_irq;
    end

    // Configuration bits
    if (hwcfg_wr) begin
      st_next.osc_run = hwcfg_osc_run;
      st_next.style   = hwcfg_style;
    end
    // Control endpoint can never be switched off
    if (ev_bus_reset)
      st_next.ep_en = EP_EN_RST;
    else if (ep_cfg_wr)
      st_next.ep_en = ep_cfg_wdata | EP_EN_RST;

    // Suspend sequencing
    st_next.prep_cnt = cnt_step(st_reg.prep_cnt, st_reg.susp == S_PREP,
                                P_PREP_CYC);
    unique case (st_reg.susp)
      S_RUN: begin
        // Processor answers the suspend flag with the command
        if (enter_suspend_cmd)
          st_next.susp = S_PREP;
        else if (frame_miss && st_reg.sof_miss == SOF_MISS_MAX - 2'h1)
          st_next.susp = S_PREP;
      end
      S_PREP: begin
        if (cnt_done(st_reg.prep_cnt, P_PREP_CYC))
          st_next.susp = S_SUSP;
      end
      S_SUSP: begin
        if (ev_resume || !st_reg.bus_idle)
          st_next.susp = S_RUN;
      end
    endcase
    st_next.susp_ind = (st_next.susp == S_SUSP);
    st_next.osc_en = st_next.osc_run && st_next.susp != S_SUSP;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg          <= '0;
      st_reg.irq_n    <= 1'b1;
      st_reg.susp     <= S_RUN;
      st_reg.osc_run  <= OSC_RUN_RST;
      st_reg.osc_en   <= OSC_RUN_RST;
      st_reg.style    <= STYLE_RST;
      st_reg.ep_en    <= EP_EN_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Power detect and clock settling, power-on reset only
  always_comb begin
    po_next = po_reg;
    po_next.vs1 = vbus_pin;
    po_next.vs2 = po_reg.vs1;
    po_next.vs3 = po_reg.vs2;
    if (po_reg.vs2 == po_reg.vs3)
      po_next.vbus = po_reg.vs3;
    po_next.vbus_cnt = cnt_step(po_reg.vbus_cnt, po_reg.vbus, P_VBUS_CYC);
    // Falls after the delay, rises at once on power loss
    po_next.vbdet_n = !(po_reg.vbus &&
                        cnt_done(po_reg.vbus_cnt, P_VBUS_CYC));
    po_next.settle_cnt = cnt_step(po_reg.settle_cnt, 1'b1, P_SETTLE_CYC);
    po_next.ready = cnt_done(po_reg.settle_cnt, P_SETTLE_CYC);
  end

  always_ff @(posedge sys_clk or negedge por_n) begin
    if (!por_n) begin
      po_reg         <= '0;
      po_reg.vbdet_n <= 1'b1;
    end else begin
      po_reg <= po_next;
    end
  end

  // ==========================================================
  // Outputs
  assign irq_n              = st_reg.irq_n;
  assign irq_status         = st_reg.status;
  assign suspend_out        = st_reg.susp_ind;
  assign osc_enable         = st_reg.osc_en;
  // Multiplier needs the oscillator, so it follows it
  assign pll_enable         = st_reg.osc_en;
  assign pll_mult           = PLL_MULT;
  assign bus_power_detect_n = po_reg.vbdet_n;
  assign clk_ready          = po_reg.ready;
  assign osc_run_bit        = st_reg.osc_run;
  assign irq_signal_style   = st_reg.style;
  assign ep_enable          = st_reg.ep_en;

  // ==========================================================
  // Checks
  a_idle_sets_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
    idle_hit && po_reg.ready |=> st_reg.status[B_SUSP])
    else $error("idle period did not set suspend flag");
  a_susp_after_prep: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(suspend_out) |-> $past(st_reg.susp) == S_PREP)
    else $error("suspend output rose without preparation");
  a_prep_holds_low: assert property (@(posedge sys_clk) disable iff (!rstn)
    st_reg.susp == S_RUN && enter_suspend_cmd |=> !suspend_out [*2])
    else $error("suspend output rose too early");
  a_vbus_delay: assert property (@(posedge sys_clk) disable iff (!por_n)
    $fell(bus_power_detect_n) |-> $past(po_reg.vbus, 2))
    else $error("power detect fell without bus power");
  a_osc_off_susp: assert property (@(posedge sys_clk) disable iff (!rstn)
    suspend_out |-> !osc_enable && !pll_enable)
    else $error("oscillator running in suspend");
  a_osc_bit_off: assert property (@(posedge sys_clk) disable iff (!rstn)
    hwcfg_wr && !hwcfg_osc_run |=> !osc_enable)
    else $error("oscillator bit did not stop oscillator");
  a_global_mask: assert property (@(posedge sys_clk) disable iff (!rstn)
    !global_irq_enable && st_reg.style != STYLE_PULSE |=> irq_n)
    else $error("interrupt with global enable off");
  a_pulse_width: assert property (@(posedge sys_clk) disable iff (!rstn)
    st_reg.style == STYLE_PULSE && $fell(irq_n) |-> !irq_n [*8] ##1 irq_n)
    else $error("interrupt pulse width wrong");
  a_read_clears: assert property (@(posedge sys_clk) disable iff (!rstn)
    irq_status_rd && !set_v[B_RESUME] |=> !irq_status[B_RESUME])
    else $error("status read did not clear flag");
  a_ep_kept: assert property (@(posedge sys_clk) disable iff (!rstn)
    irq_status_rd && ep_status_rd == '0 && st_reg.status[B_EP0]
    |=> irq_status[B_EP0])
    else $error("endpoint flag lost on status read");
  a_bus_live: assert property (@(posedge sys_clk) disable iff (!rstn)
    ##1 irq_status[B_BUS] == $past(st_reg.bus_idle))
    else $error("bus state bit not live");
  a_ctrl_ep_on: assert property (@(posedge sys_clk) disable iff (!rstn)
    ep_enable[0])
    else $error("control endpoint disabled");
  a_level_irq: assert property (@(posedge sys_clk) disable iff (!rstn)
    st_reg.style != STYLE_PULSE && $past(st_reg.style) != STYLE_PULSE
    |-> irq_n == !$past(any_irq))
    else $error("level interrupt does not follow status");

  c_suspend: cover property (@(posedge sys_clk) disable iff (!rstn)
    $rose(suspend_out));
  c_pulse: cover property (@(posedge sys_clk) disable iff (!rstn)
    st_reg.style == STYLE_PULSE && $fell(irq_n));
  c_pframe: cover property (@(posedge sys_clk) disable iff (!rstn)
    frame_miss && st_reg.sof_miss == 2'h2);
  c_vbus: cover property (@(posedge sys_clk) disable iff (!por_n)
    $fell(bus_power_detect_n));

endmodule : uisc_ctrl

// File: dv/uisc_proc_model.sv
// Processor model that services the interrupt output of the controller
module uisc_proc_model
  import uisc_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            rstn,
  input  wire logic            irq_n,
  input  wire logic [ST_W-1:0] irq_status,
  input  wire logic            auto_en,
  input  wire logic [3:0]      delay,
  input  wire logic            rd_req,
  output logic                 irq_status_rd,
  output logic                 enter_suspend_cmd
);
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic       auto_rd;
    logic       cmd;
    logic [1:0] phase;
    logic [3:0] cnt;
  } uisc_pm_s;

  uisc_pm_s pm_reg, pm_next;

  assign irq_status_rd     = pm_reg.auto_rd | rd_req;
  assign enter_suspend_cmd = pm_reg.cmd;

  // ==========================================================
  // Service loop
  // Cool-down phase, since irq_n lingers low for two cycles after a read
  always_comb begin
    pm_next         = pm_reg;
    pm_next.auto_rd = 1'b0;
    pm_next.cmd     = 1'b0;
    case (pm_reg.phase)
      2'd0: begin
        if (auto_en && !irq_n) begin
          pm_next.phase = 2'd1;
          pm_next.cnt   = delay;
        end
      end
      2'd1: begin
        if (pm_reg.cnt == 4'h0) begin
          pm_next.auto_rd = 1'b1;
          pm_next.cmd     = irq_status[B_SUSP];
          pm_next.phase   = 2'd2;
          pm_next.cnt     = 4'h6;
        end else begin
          pm_next.cnt = pm_reg.cnt - 4'h1;
        end
      end
      default: begin
        if (pm_reg.cnt == 4'h0)
          pm_next.phase = 2'd0;
        else
          pm_next.cnt = pm_reg.cnt - 4'h1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      pm_reg <= '0;
    else
      pm_reg <= pm_next;
  end
endmodule : uisc_proc_model

// File: dv/usb_irq_suspend_ctrl_test.sv
// Self-checking testbench of the interrupt and suspend controller
module usb_irq_suspend_ctrl_test;
  import uisc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int T_IDLE = 40;
  localparam int T_PREP = 20;
  localparam int T_VBUS = 30;
  localparam int T_SET  = 10;
  localparam int T_FRM  = 25;
  // Bus state, frame and pseudo-frame bits are checked on their own
  localparam logic [ST_W-1:0] CMP_MASK = 24'hFF_FF67;

  logic            sys_clk, rstn, por_n, bus_idle_pin, vbus_pin;
  logic            ev_bus_reset, ev_resume, ev_sof, ev_short_packet_end_flag, ev_eot;
  logic [N_EP-1:0] ep_pkt_acked, ep_iso_txn, ep_is_iso, ep_status_rd;
  logic [N_EP-1:0] ep_cfg_wdata, ep_enable, a, t, iso, v;
  logic [ST_W-1:0] irq_enable, irq_status, exp_st;
  logic            global_irq_enable, hwcfg_wr, hwcfg_osc_run, hwcfg_style;
  logic            ep_cfg_wr, irq_status_rd, enter_suspend_cmd, irq_n;
  logic            suspend_out, osc_enable, pll_enable, clk_ready;
  logic            bus_power_detect_n, osc_run_bit, irq_signal_style;
  logic [3:0]      pll_mult, delay;
  logic            auto_en, rd_req, sof_on;
  int              errors, checks, n;
  integer          seed;

  uisc_ctrl #(.P_IDLE_CYC(T_IDLE), .P_PREP_CYC(T_PREP), .P_VBUS_CYC(T_VBUS),
    .P_SETTLE_CYC(T_SET), .P_FRAME_CYC(T_FRM)) i_uisc_ctrl (.sys_clk, .rstn,
    .por_n, .bus_idle_pin, .vbus_pin, .enter_suspend_cmd, .ev_bus_reset,
    .ev_resume, .ev_sof, .ev_short_packet_end_flag, .ev_eot, .ep_pkt_acked, .ep_iso_txn,
    .ep_is_iso, .irq_status_rd, .ep_status_rd, .irq_enable,
    .global_irq_enable, .hwcfg_wr, .hwcfg_osc_run, .hwcfg_style, .ep_cfg_wr,
    .ep_cfg_wdata, .irq_n, .irq_status, .suspend_out, .osc_enable,
    .pll_enable, .pll_mult, .bus_power_detect_n, .clk_ready, .osc_run_bit,
    .irq_signal_style, .ep_enable);

  uisc_proc_model i_uisc_proc_model (.sys_clk, .rstn, .irq_n, .irq_status,
    .auto_en, .delay, .rd_req, .irq_status_rd, .enter_suspend_cmd);

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : chk_rng

  task automatic finish_test;
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : tick

  // Ends the one-cycle strobes raised by the caller at the previous edge
  task automatic pulse_end;
    @(posedge sys_clk);
    {ev_bus_reset, ev_resume, ev_short_packet_end_flag, ev_eot} <= 4'h0;
    {rd_req, hwcfg_wr, ep_cfg_wr} <= 3'h0;
    ep_pkt_acked <= '0;
    ep_iso_txn   <= '0;
    ep_status_rd <= '0;
  endtask : pulse_end

  task automatic check_irq;
    chk(irq_status & CMP_MASK, exp_st & CMP_MASK);
    chk(irq_n, !(|(exp_st & irq_enable) && global_irq_enable));
  endtask : check_irq

  task automatic wait_susp(input int lim);
    while (!suspend_out && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask : wait_susp

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Frame starts keep the missed-frame logic quiet unless switched off
  initial begin
    ev_sof = 1'b0;
    forever begin
      tick(20);
      if (sof_on) begin
        ev_sof <= 1'b1;
        @(posedge sys_clk);
        ev_sof <= 1'b0;
      end
    end
  end

  initial begin
    #200_000;
    errors++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {rstn, por_n, bus_idle_pin, vbus_pin, auto_en, rd_req} = '0;
    {ev_bus_reset, ev_resume, ev_short_packet_end_flag, ev_eot, global_irq_enable} = '0;
    {hwcfg_wr, hwcfg_osc_run, hwcfg_style, ep_cfg_wr} = '0;
    {ep_pkt_acked, ep_iso_txn, ep_is_iso, ep_status_rd, ep_cfg_wdata} = '0;
    irq_enable = '0;
    delay = 4'h0;
    sof_on = 1'b1;
    errors = 0;
    checks = 0;
    exp_st = '0;
    seed = 32'hd8b7f485;
    tick(4);
    rstn <= 1'b1;
    por_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk({irq_n, suspend_out, osc_enable, pll_enable}, 4'hB);
    chk({irq_signal_style, osc_run_bit}, 2'b01);
    chk(ep_enable, EP_EN_RST);
    chk(pll_mult, 4'h8);
    chk({bus_power_detect_n, clk_ready}, 2'b10);
    tick(T_SET + 1);
    #1;
    chk(clk_ready, 1'b1);
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      n = $random(seed);
      a = 16'($random(seed));
      t = 16'($random(seed));
      iso = 16'($random(seed));
      {ev_eot, ev_short_packet_end_flag, ev_resume, ev_bus_reset} <= n[3:0];
      ep_pkt_acked <= a;
      ep_iso_txn <= t;
      ep_is_iso <= iso;
      irq_enable <= 24'($random(seed)) & CMP_MASK;
      global_irq_enable <= n[4];
      pulse_end();
      exp_st |= {(a & ~iso) | (t & iso), 1'b0, n[3:2], 2'b0, n[1], 1'b0, n[0]};
      tick(2);
      #1;
      check_irq();
      if (i % 4 == 3) begin
        @(posedge sys_clk);
        v = 16'($random(seed));
        rd_req <= 1'b1;
        ep_status_rd <= v;
        pulse_end();
        exp_st &= ~{v, 8'h7F};
        tick(2);
        #1;
        check_irq();
      end
    end
    for (int b = 1; b >= 0; b--) begin
      @(posedge sys_clk);
      bus_idle_pin <= b[0];
      tick(6);
      #1;
      chk(irq_status[B_BUS], b[0]);
    end
    @(posedge sys_clk);
    {rd_req, hwcfg_wr, hwcfg_style, hwcfg_osc_run} <= {3'b111, STYLE_PULSE};
    ep_status_rd <= '1;
    irq_enable <= 24'h00_0040;
    global_irq_enable <= 1'b1;
    pulse_end();
    tick(3);
    #1;
    chk({irq_signal_style, irq_n}, 2'b11);
    // A second event while the flag is still set must not pulse again
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      ev_eot <= 1'b1;
      pulse_end();
      n = 0;
      repeat (14) begin
        @(posedge sys_clk);
        #1;
        if (irq_n === 1'b0) n++;
      end
      chk_rng(n, (k == 0) ? 8 : 0, (k == 0) ? 8 : 0);
    end
    // Frame starts come every 21 cycles, so one has landed since the read
    chk(irq_status[B_SOF], 1'b1);
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      {hwcfg_wr, hwcfg_osc_run, hwcfg_style, rd_req} <= {1'b1, k[0], 2'b01};
      pulse_end();
      tick(1);
      #1;
      chk({osc_run_bit, osc_enable}, {2{k[0]}});
    end
    @(posedge sys_clk);
    irq_enable <= 24'h00_0002;
    auto_en <= 1'b1;
    delay <= 4'($random(seed));
    bus_idle_pin <= 1'b1;
    n = 0;
    wait_susp(400);
    chk_rng(n, T_IDLE + T_PREP, T_IDLE + T_PREP + 40);
    chk({osc_enable, pll_enable}, 2'b00);
    @(posedge sys_clk);
    bus_idle_pin <= 1'b0;
    auto_en <= 1'b0;
    tick(8);
    #1;
    chk({suspend_out, osc_enable, pll_enable}, 3'b011);
    @(posedge sys_clk);
    sof_on <= 1'b0;
    rd_req <= 1'b1;
    irq_enable <= 24'h00_0010;
    pulse_end();
    tick(T_FRM + 1);
    #1;
    chk({irq_status[B_PFRAME], irq_n}, 2'b10);
    n = T_FRM + 2;
    wait_susp(300);
    chk_rng(n, 2 * T_FRM + T_PREP, 3 * T_FRM + T_PREP + 25);
    @(posedge sys_clk);
    sof_on <= 1'b1;
    v = 16'($random(seed));
    ep_cfg_wr <= 1'b1;
    ep_cfg_wdata <= v;
    vbus_pin <= 1'b1;
    pulse_end();
    tick(1);
    #1;
    chk(ep_enable, v | 16'h0001);
    n = 2;
    while (bus_power_detect_n && n < 100) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk_rng(n, T_VBUS, T_VBUS + 6);
    @(posedge sys_clk);
    rstn <= 1'b0;
    tick(2);
    rstn <= 1'b1;
    tick(1);
    #1;
    chk(bus_power_detect_n, 1'b0);
    chk({ep_enable, irq_signal_style}, {EP_EN_RST, STYLE_RST});
    @(posedge sys_clk);
    vbus_pin <= 1'b0;
    tick(7);
    #1;
    chk(bus_power_detect_n, 1'b1);
    finish_test();
  end
endmodule : usb_irq_suspend_ctrl_test
